/* rtl/acr_pkg.sv */
package acr_pkg;

    // ==========================================
    // Register offsets
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATE_CTRL = 8'h04;
    localparam logic [7:0] ADDR_FAULT_CTRL = 8'h21;
    localparam logic [7:0] ADDR_CLIP_CTRL = 8'h22;
    localparam logic [7:0] ADDR_CLIP_WINDOW = 8'h23;
    localparam logic [7:0] ADDR_CLIP_FLAGS = 8'h24;
    localparam logic [7:0] ADDR_ILIM_FLAGS = 8'h25;
    localparam logic [7:0] ADDR_FILTER_CTRL = 8'h26;

    // ==========================================
    // Reset values
    localparam logic [7:0] RST_MODE_CTRL = 8'h00;
    localparam logic [7:0] RST_STATE_CTRL = 8'h00;
    localparam logic [7:0] RST_FAULT_CTRL = 8'h00;
    localparam logic [7:0] RST_CLIP_CTRL = 8'h01;
    localparam logic [7:0] RST_CLIP_WINDOW = 8'h14;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_FILTER_CTRL = 8'h40;
    localparam logic [7:0] CLIP_WINDOW_MAX = 8'h14;

    // ==========================================
    // Field positions
    localparam int MODE_PAIR12_BIT = 0;
    localparam int MODE_PAIR34_BIT = 1;
    localparam int MODE_FSW_LSB = 2;
    localparam int MODE_LINE_LSB = 4;
    localparam int FAULT_MASK_ILIM_BIT = 5;
    localparam int FAULT_CLEAR_BIT = 7;
    localparam int CLIP_EN_BIT = 0;
    localparam logic [7:0] FILTER_WMASK = 8'h07;

    // Channel states, two bits each
    typedef enum logic [1:0] {
        ACR_ST_STANDBY = 2'b00,
        ACR_ST_MUTE = 2'b01,
        ACR_ST_PLAY = 2'b11,
        ACR_ST_HIZ = 2'b10
    } acr_state_t;

    // Switching frequency choices, in multiples of the sample rate
    typedef enum logic [2:0] {
        ACR_FSW_38 = 3'h0,
        ACR_FSW_44 = 3'h1,
        ACR_FSW_48 = 3'h3,
        ACR_FSW_8 = 3'h2,
        ACR_FSW_10 = 3'h6
    } acr_fsw_t;

endpackage

/* rtl/acr_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// - Read-only clip flags at 0x24, bits 0-3 per channel, reset zero.
// - Read-only current-limit flags at 0x25, bits 0-3 per channel, upper zero.
// - Three-bit high-pass corner field at 0x26 bits 2:0, reset code 000.
// - Filter register upper five bits reset to 01000, default 0x40.
// - Read/write clip window select, reset 0x14, codes 0x00 to 0x14.
// - Switching frequency choices 38, 44, 48 fs above AM, 8 or 10 below.
// - Paralleled channels need equal states; mismatch raises a fault.
// - Parallel-bridge mode changes only take effect while in standby.
// - Load diagnostics allowed on parallel-bridge channels.
// - Per-channel line-driver mode selected in register 0x00.
// - Clip detection enabled by default via bit 0 of 0x22.
// - Current-limit events drive the warning pin unless masked.
module acr_regs #(
    parameter int NCH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port from the serial controller
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Channel monitors
    input wire logic [NCH-1:0] clip_event,
    input wire logic [NCH-1:0] current_limit_event,
    input wire logic diag_request,
    // Controls to the output stages
    output logic [NCH-1:0] line_driver_mode,
    output logic [1:0] parallel_bridge_mode,
    output logic [2:0] switch_freq_sel,
    output logic [2:0] highpass_corner_sel,
    output logic [7:0] clip_window_sel,
    output logic clip_detect_on,
    output logic diag_enable,
    // Status pins
    output logic warn_n,
    output logic parallel_fault
);

    // ==========================================
    // Register state
    logic [7:0] mode_r, mode_nxt;
    logic [7:0] state_r, state_nxt;
    logic [7:0] fault_r, fault_nxt;
    logic [7:0] clipc_r, clipc_nxt;
    logic [7:0] window_r, window_nxt;
    logic [7:0] filter_r, filter_nxt;
    logic [NCH-1:0] clip_r, clip_nxt;
    logic [NCH-1:0] ilim_r, ilim_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic pfault_r, pfault_nxt;
    logic [NCH-1:0] line_mask;

    function automatic logic all_standby(input logic [7:0] st);
        all_standby = (st == {4{acr_pkg::ACR_ST_STANDBY}});
    endfunction

    function automatic logic [7:0] pad_flags(input logic [NCH-1:0] f);
        pad_flags = 8'h00;
        pad_flags[NCH-1:0] = f;
    endfunction

    // ==========================================
    // Next-state logic
    always_comb
    begin
        mode_nxt = mode_r;
        state_nxt = state_r;
        fault_nxt = fault_r;
        clipc_nxt = clipc_r;
        window_nxt = window_r;
        filter_nxt = filter_r;
        rdata_nxt = rdata_r;
        // Flags are sticky; a new event beats the clear in the same cycle
        clip_nxt = clip_r | (clip_event & {NCH{clipc_r[acr_pkg::CLIP_EN_BIT]}});
        ilim_nxt = ilim_r | current_limit_event;
        if (reg_wr)
        begin
            case (reg_addr)
                acr_pkg::ADDR_MODE_CTRL:
                begin
                    // Bridge pairing is only re-wired from standby
                    mode_nxt[7:2] = reg_wdata[7:2];
                    if (all_standby(state_r))
                    begin
                        mode_nxt[1:0] = reg_wdata[1:0];
                    end
                end
                acr_pkg::ADDR_STATE_CTRL: state_nxt = reg_wdata;
                acr_pkg::ADDR_FAULT_CTRL:
                begin
                    fault_nxt = reg_wdata & 8'h7F;
                    if (reg_wdata[acr_pkg::FAULT_CLEAR_BIT])
                    begin
                        clip_nxt = clip_event & {NCH{clipc_r[acr_pkg::CLIP_EN_BIT]}};
                        ilim_nxt = current_limit_event;
                    end
                end
                acr_pkg::ADDR_CLIP_CTRL: clipc_nxt = reg_wdata & 8'h01;
                acr_pkg::ADDR_CLIP_WINDOW:
                begin
                    // Undefined codes are dropped, keeping the window sane
                    if (reg_wdata <= acr_pkg::CLIP_WINDOW_MAX)
                    begin
                        window_nxt = reg_wdata;
                    end
                end
                acr_pkg::ADDR_FILTER_CTRL: filter_nxt = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                acr_pkg::ADDR_MODE_CTRL: rdata_nxt = mode_r;
                acr_pkg::ADDR_STATE_CTRL: rdata_nxt = state_r;
                acr_pkg::ADDR_FAULT_CTRL: rdata_nxt = fault_r;
                acr_pkg::ADDR_CLIP_CTRL: rdata_nxt = clipc_r;
                acr_pkg::ADDR_CLIP_WINDOW: rdata_nxt = window_r;
                acr_pkg::ADDR_CLIP_FLAGS: rdata_nxt = pad_flags(clip_r);
                acr_pkg::ADDR_ILIM_FLAGS: rdata_nxt = pad_flags(ilim_r);
                acr_pkg::ADDR_FILTER_CTRL: rdata_nxt = filter_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
        // Paralleled pairs must share one state
        pfault_nxt = (mode_r[acr_pkg::MODE_PAIR12_BIT] && state_r[1:0] != state_r[3:2])
            || (mode_r[acr_pkg::MODE_PAIR34_BIT] && state_r[5:4] != state_r[7:6]);
    end

    // ==========================================
    // Registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_r <= acr_pkg::RST_MODE_CTRL;
            state_r <= acr_pkg::RST_STATE_CTRL;
            fault_r <= acr_pkg::RST_FAULT_CTRL;
            clipc_r <= acr_pkg::RST_CLIP_CTRL;
            window_r <= acr_pkg::RST_CLIP_WINDOW;
            filter_r <= acr_pkg::RST_FILTER_CTRL;
            clip_r <= '0;
            ilim_r <= '0;
            rdata_r <= acr_pkg::RST_FLAGS;
            pfault_r <= 1'b0;
        end
        else if (clk_en)
        begin
            mode_r <= mode_nxt;
            state_r <= state_nxt;
            fault_r <= fault_nxt;
            clipc_r <= clipc_nxt;
            window_r <= window_nxt;
            filter_r <= filter_nxt;
            clip_r <= clip_nxt;
            ilim_r <= ilim_nxt;
            rdata_r <= rdata_nxt;
            pfault_r <= pfault_nxt;
        end
    end

    // ==========================================
    // Outputs
    assign line_mask = mode_r[acr_pkg::MODE_LINE_LSB +: NCH];
    assign line_driver_mode = line_mask;
    assign parallel_bridge_mode = mode_r[1:0];
    assign switch_freq_sel = {mode_r[7] & mode_r[3], mode_r[3:2]};
    assign highpass_corner_sel = filter_r[2:0];
    assign clip_window_sel = window_r;
    assign clip_detect_on = clipc_r[acr_pkg::CLIP_EN_BIT];
    // Diagnostics run from standby whatever the bridge pairing
    assign diag_enable = diag_request && all_standby(state_r);
    assign warn_n = ~((|ilim_r) && !fault_r[acr_pkg::FAULT_MASK_ILIM_BIT]);
    assign parallel_fault = pfault_r;
    assign reg_rdata = rdata_r;

    // ==========================================
    // Checks
    AST_FILTER_RESET: assert property (@(posedge clk)
        $rose(rst_n) |-> filter_r == acr_pkg::RST_FILTER_CTRL)
        else $error("filter default wrong");
    AST_CLIP_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && clip_event[0] && clipc_r[acr_pkg::CLIP_EN_BIT] |=> clip_r[0])
        else $error("clip flag not set");
    AST_ILIM_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && current_limit_event[1] |=> ilim_r[1])
        else $error("current limit flag not set");
    AST_FLAG_RO: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && reg_wr && reg_addr == acr_pkg::ADDR_CLIP_FLAGS && clip_event == '0
        |=> clip_r == $past(clip_r))
        else $error("clip flags changed by a write");
    AST_HPF_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && reg_wr && reg_addr == acr_pkg::ADDR_FILTER_CTRL
        |=> highpass_corner_sel == $past(reg_wdata[2:0]))
        else $error("corner not written");
    AST_WINDOW_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
        window_r <= acr_pkg::CLIP_WINDOW_MAX)
        else $error("clip window out of range");
    AST_PAR_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && mode_r[acr_pkg::MODE_PAIR12_BIT] && state_r[1:0] != state_r[3:2]
        |=> parallel_fault)
        else $error("parallel fault missing");
    AST_PAR_FAULT34: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && mode_r[acr_pkg::MODE_PAIR34_BIT] && state_r[5:4] != state_r[7:6]
        |=> parallel_fault)
        else $error("second pair fault missing");
    AST_NO_FALSE_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && mode_r[1:0] == 2'b00 |=> !parallel_fault)
        else $error("fault raised with no pairing");
    AST_PAIR_STANDBY: assert property (@(posedge clk) disable iff (!rst_n)
        !all_standby(state_r) |=> $stable(mode_r[1:0]) || !$past(clk_en))
        else $error("bridge mode changed outside standby");
    AST_WARN_MASK: assert property (@(posedge clk) disable iff (!rst_n)
        fault_r[acr_pkg::FAULT_MASK_ILIM_BIT] |-> warn_n)
        else $error("masked warning reached pin");
    AST_CLIP_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && !clipc_r[acr_pkg::CLIP_EN_BIT] && !clip_r[2] |=> !clip_r[2])
        else $error("clip flag set while disabled");
    AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        $past(reg_rd && clk_en && reg_addr == acr_pkg::ADDR_ILIM_FLAGS) |-> reg_rdata[7:4] == 4'h0)
        else $error("reserved bits not zero");
    AST_RSVD_ZERO_CLIP: assert property (@(posedge clk) disable iff (!rst_n)
        $past(reg_rd && clk_en && reg_addr == acr_pkg::ADDR_CLIP_FLAGS) |-> reg_rdata[7:4] == 4'h0)
        else $error("reserved clip bits not zero");

endmodule

/* test/acr_host.sv */
`timescale 1ns/1ps
// ==========================================
// Host side of the register port
module acr_host (
    // Clock
    input wire logic clk,
    // Register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Released lines show the inverse so stale values never pass as valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule

/* test/amp_clip_current_limit_event_hpf_regs_tb_top.sv */
`timescale 1ns/1ps
module amp_clip_current_limit_event_hpf_regs_tb_top;
    // ==========================================
    // Stimulus and observation
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic reg_wr, reg_rd, clip_detect_on, diag_enable, warn_n, parallel_fault;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, clip_window_sel, d;
    logic [3:0] clip_event = 4'h0;
    logic [3:0] current_limit_event = 4'h0;
    logic [3:0] line_driver_mode;
    logic diag_request = 1'b0;
    logic [1:0] parallel_bridge_mode;
    logic [2:0] switch_freq_sel, highpass_corner_sel;
    int err_count = 0;
    int tests_run = 0;
    always #12.5 clk = ~clk;
    acr_host i_host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
    acr_regs #(.NCH(4)) i_dut (.clk, .rst_n, .clk_en, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .clip_event, .current_limit_event, .diag_request,
        .line_driver_mode, .parallel_bridge_mode, .switch_freq_sel, .highpass_corner_sel,
        .clip_window_sel, .clip_detect_on, .diag_enable, .warn_n, .parallel_fault);
    // ==========================================
    // Shared helpers
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic pulse(input logic [3:0] c, input logic [3:0] l);
        @(negedge clk);
        clip_event = c;
        current_limit_event = l;
        @(negedge clk);
        clip_event = 4'h0;
        current_limit_event = 4'h0;
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] a [7] = '{8'h00, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26};
        logic [7:0] e [7] = '{8'h00, 8'h00, 8'h01, 8'h14, 8'h00, 8'h00, 8'h40};
        chk("rdata reset", reg_rdata, 8'h00);
        chk("fault reset", {7'h00, parallel_fault}, 8'h00);
        for (int i = 0; i < 7; i++)
        begin
            i_host.rd(a[i], d);
            chk("reset", d, e[i]);
        end
        chk("warn idle", {7'h00, warn_n}, 8'h01);
    endtask
    task automatic t_filter();
        for (int i = 0; i < 8; i++)
        begin
            i_host.wr(8'h26, 8'h40 | 8'(i));
            chk("corner", {5'h00, highpass_corner_sel}, 8'(i));
            i_host.rd(8'h26, d);
            chk("filter", d, 8'h40 | 8'(i));
        end
        // A write while the enable is low must leave every register alone
        clk_en = 1'b0;
        i_host.wr(8'h26, 8'h41);
        chk("freeze", {5'h00, highpass_corner_sel}, 8'h07);
        clk_en = 1'b1;
        i_host.rd(8'h26, d);
        chk("freeze", d, 8'h47);
    endtask
    task automatic t_window();
        i_host.wr(8'h23, 8'h00);
        chk("window", clip_window_sel, 8'h00);
        i_host.wr(8'h23, 8'h15);
        chk("window", clip_window_sel, 8'h00);
        i_host.wr(8'h23, 8'h14);
        i_host.rd(8'h23, d);
        chk("window", d, 8'h14);
    endtask
    task automatic t_flags();
        pulse(4'h5, 4'hA);
        i_host.wr(8'h24, 8'hFF);
        i_host.rd(8'h24, d);
        chk("clip", d, 8'h05);
        i_host.rd(8'h25, d);
        chk("ilim", d, 8'h0A);
        chk("warn", {7'h00, warn_n}, 8'h00);
        i_host.wr(8'h21, 8'h20);
        chk("warn mask", {7'h00, warn_n}, 8'h01);
        i_host.wr(8'h21, 8'hA0);
        i_host.rd(8'h25, d);
        chk("ilim", d, 8'h00);
        i_host.wr(8'h22, 8'h00);
        chk("clip on", {7'h00, clip_detect_on}, 8'h00);
        pulse(4'hF, 4'h0);
        i_host.rd(8'h24, d);
        chk("clip", d, 8'h00);
    endtask
    task automatic t_mode();
        logic [7:0] m [5] = '{8'h01, 8'h15, 8'h2D, 8'h49, 8'h89};
        logic [2:0] f [5] = '{acr_pkg::ACR_FSW_38, acr_pkg::ACR_FSW_44, acr_pkg::ACR_FSW_48,
            acr_pkg::ACR_FSW_8, acr_pkg::ACR_FSW_10};
        i_host.wr(8'h04, 8'h0F);
        i_host.wr(8'h00, 8'h01);
        chk("pair", {6'h00, parallel_bridge_mode}, 8'h00);
        i_host.wr(8'h04, 8'h00);
        i_host.wr(8'h00, 8'h01);
        chk("pair", {6'h00, parallel_bridge_mode}, 8'h01);
        diag_request = 1'b1;
        #1 chk("diag", {7'h00, diag_enable}, 8'h01);
        i_host.wr(8'h04, 8'h03);
        chk("diag", {7'h00, diag_enable}, 8'h00);
        @(negedge clk);
        chk("fault", {7'h00, parallel_fault}, 8'h01);
        i_host.wr(8'h04, 8'h0F);
        @(negedge clk);
        chk("fault", {7'h00, parallel_fault}, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            i_host.wr(8'h00, m[i]);
            chk("fsw", {5'h00, switch_freq_sel}, {5'h00, f[i]});
            chk("line", {4'h0, line_driver_mode}, {4'h0, m[i][7:4]});
        end
    endtask
    task automatic t_race();
        // Event held across the clear edge: the set must win
        @(negedge clk);
        current_limit_event = 4'h1;
        @(negedge clk);
        current_limit_event = 4'h2;
        i_host.wr(8'h21, 8'h80);
        current_limit_event = 4'h0;
        i_host.rd(8'h25, d);
        chk("set wins", d, 8'h02);
        chk("warn", {7'h00, warn_n}, 8'h00);
    endtask
    task automatic t_pair34();
        i_host.wr(8'h04, 8'h00);
        i_host.wr(8'h00, 8'h02);
        chk("pair", {6'h00, parallel_bridge_mode}, 8'h02);
        i_host.wr(8'h04, 8'h10);
        @(negedge clk);
        chk("fault", {7'h00, parallel_fault}, 8'h01);
        i_host.wr(8'h04, 8'h50);
        @(negedge clk);
        chk("fault", {7'h00, parallel_fault}, 8'h00);
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial
    begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_filter();
        t_window();
        t_flags();
        t_race();
        t_mode();
        t_pair34();
        complete_run();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        complete_run();
    end
endmodule
